// ### include/lem_defines.svh
`ifndef LEM_DEFINES_SVH
`define LEM_DEFINES_SVH
// register byte offsets
`define LEM_OFF_CTRL     8'h00
`define LEM_OFF_MODE     8'h04
`define LEM_OFF_CSEL     8'h08
`define LEM_OFF_START    8'h0C
`define LEM_OFF_CLKSEL   8'h10
`define LEM_OFF_PACK     8'h14
`define LEM_OFF_STATUS   8'h30
`define LEM_OFF_LUT0     8'h40
// field positions
`define LEM_CTRL_RSTEN   0
`define LEM_FLD_LO       0
`define LEM_FLD_MID      10
`define LEM_FLD_HI       20
`define LEM_STAT_CARRY   10
`define LEM_STAT_CHIP    11
// geometry and reset values
`define LEM_N            10
`define LEM_GROUP        5
`define LEM_RST_CFG      10'h000
`define LEM_RST_MASK     16'h0000
`endif

// ### include/lem_pkg.sv
package lem_pkg;
    // operating mode of one logic element
    typedef enum logic [1:0] {
        LEM_NORMAL = 2'b01,
        LEM_ARITH  = 2'b10
    } lem_mode_type;
    typedef logic [15:0] lem_mask_type;
endpackage

// ### rtl/lem_lab.sv
`timescale 1ns/100ps
`default_nettype none
`include "lem_defines.svh"

module lem_lab
    import lem_pkg::*;
(
    input  wire logic        hclk,              // system clock
    input  wire logic        hresetn,           // async reset, active low
    input  wire logic        clk_en,            // freezes all state except hreadyout and hresp when low
    input  wire logic        hsel,              // ahb select
    input  wire logic [31:0] haddr,             // ahb address
    input  wire logic [1:0]  htrans,            // ahb transfer type
    input  wire logic        hwrite,            // ahb write
    input  wire logic [2:0]  hsize,             // ahb size
    input  wire logic [31:0] hwdata,            // ahb write data
    input  wire logic        hready,            // ahb bus ready
    output logic      [31:0] hrdata,            // ahb read data
    output logic             hreadyout,         // ahb slave ready
    output logic             hresp,             // ahb response
    input  wire logic [9:0]  din_a,             // first data input per element
    input  wire logic [9:0]  din_b,             // second data input per element
    input  wire logic [9:0]  din_c,             // third data input per element
    input  wire logic [9:0]  fourth_data_input, // fourth data input per element
    input  wire logic        block_carry_in,    // carry from previous block
    input  wire logic        lut_chain_in,      // table chain into element 0
    input  wire logic        reg_chain_in,      // register chain into element 0
    input  wire logic [1:0]  lab_clk_ena,       // two block clock enables
    input  wire logic [1:0]  async_clr,         // two block clears, active high
    input  wire logic        async_load,        // block preset/load, active high
    input  wire logic        sync_clr,          // block synchronous clear
    input  wire logic        sync_load,         // block synchronous load
    input  wire logic        add_sub,           // 1 = subtract
    input  wire logic        chip_wide_reset_n, // chip reset pin, active low
    output logic      [9:0]  comb_out,          // table or sum output per element
    output logic      [9:0]  reg_out,           // element registers
    output logic             lut_chain_out,     // table chain to next block
    output logic             reg_chain_out,     // register chain to next block
    output logic             block_carry_out    // final carry to next block
);
    logic [9:0]   mode;          // 1 = arithmetic
    logic [9:0]   csel;          // normal: carry instead of fourth input
    logic [9:0]   start;         // element begins a carry chain
    logic [9:0]   ce_sel;
    logic [9:0]   clr_sel;
    logic [9:0]   lchain;        // table input a from table chain
    logic [9:0]   rsrc;          // register data from register chain
    logic [9:0]   cnt;           // counter mode in arithmetic
    logic [9:0]   preset;        // async load drives high
    logic         rst_en;
    lem_mask_type lut_mask [0:9];
    logic         chip_s1;
    logic         chip_ok;
    logic [9:0]   reg_q;
    logic [9:0]   tout;
    logic [9:0]   aclr_v;
    logic [9:0]   ce_v;
    logic [10:0]  cz;            // zero-assumed chain carries
    logic [10:0]  co;            // one-assumed chain carries
    logic [10:0]  lutc;
    logic [10:0]  rch;
    logic         gsel0;
    logic         gsel1;
    logic         fin_carry;
    logic         a_act;
    logic         a_wr;
    logic [7:0]   a_addr;
    logic         a_ok;
    logic [31:0]  next_hrdata;
    logic [10:0]  exp_sum;

    // chip reset pin crosses in through two flops
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            chip_s1 <= 1'b1;
            chip_ok <= 1'b1;
        end
        else if (clk_en)
        begin
            chip_s1 <= chip_wide_reset_n;
            chip_ok <= chip_s1;
        end
    end

    // ahb address phase capture; single cycle answer, no wait states
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            a_wr   <= 1'b0;
            a_addr <= 8'h00;
        end
        else if (clk_en)
        begin
            a_wr   <= hsel && hready && htrans[1] && hwrite && (haddr[31:8] == 24'h000000);
            a_addr <= haddr[7:0];
        end
    end

    assign a_act = hsel && hready && htrans[1] && !hwrite;
    assign a_ok  = (haddr[31:8] == 24'h000000);

    // response is always okay and never stretched
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            hreadyout <= 1'b0;
            hresp     <= 1'b0;
        end
        else
        begin
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
        end
    end

    // read mux, evaluated in the address phase so data is ready next cycle
    always_comb
    begin
        next_hrdata = 32'h00000000;
        if (a_act && a_ok)
        begin
            unique case (haddr[7:0])
                `LEM_OFF_CTRL:   next_hrdata = {31'h0, rst_en};
                `LEM_OFF_MODE:   next_hrdata = {22'h0, mode};
                `LEM_OFF_CSEL:   next_hrdata = {22'h0, csel};
                `LEM_OFF_START:  next_hrdata = {22'h0, start};
                `LEM_OFF_CLKSEL: next_hrdata = {2'h0, lchain, clr_sel, ce_sel};
                `LEM_OFF_PACK:   next_hrdata = {2'h0, preset, cnt, rsrc};
                `LEM_OFF_STATUS: next_hrdata = {20'h0, chip_ok, fin_carry, reg_q};
                default:
                    if (haddr[7:6] == 2'b01 && haddr[5:2] < 4'hA)
                        next_hrdata = {16'h0, lut_mask[haddr[5:2]]};
            endcase
        end
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            hrdata <= 32'h00000000;
        else if (clk_en)
            hrdata <= next_hrdata;
    end

    // configuration writes in the data phase
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            rst_en  <= 1'b0;
            mode    <= `LEM_RST_CFG;
            csel    <= `LEM_RST_CFG;
            start   <= `LEM_RST_CFG;
            ce_sel  <= `LEM_RST_CFG;
            clr_sel <= `LEM_RST_CFG;
            lchain  <= `LEM_RST_CFG;
            rsrc    <= `LEM_RST_CFG;
            cnt     <= `LEM_RST_CFG;
            preset  <= `LEM_RST_CFG;
            for (int k = 0; k < `LEM_N; k++)
                lut_mask[k] <= `LEM_RST_MASK;
        end
        else if (clk_en && a_wr)
        begin
            unique case (a_addr)
                `LEM_OFF_CTRL:  rst_en <= hwdata[`LEM_CTRL_RSTEN];
                `LEM_OFF_MODE:  mode   <= hwdata[9:0];  // one bit per element
                `LEM_OFF_CSEL:  csel   <= hwdata[9:0];
                `LEM_OFF_START: start  <= hwdata[9:0];
                `LEM_OFF_CLKSEL:
                begin
                    ce_sel  <= hwdata[`LEM_FLD_LO +: 10];
                    clr_sel <= hwdata[`LEM_FLD_MID +: 10];
                    lchain  <= hwdata[`LEM_FLD_HI +: 10];
                end
                `LEM_OFF_PACK:
                begin
                    rsrc   <= hwdata[`LEM_FLD_LO +: 10];
                    cnt    <= hwdata[`LEM_FLD_MID +: 10];
                    preset <= hwdata[`LEM_FLD_HI +: 10];
                end
                default:
                    if (a_addr[7:6] == 2'b01 && a_addr[5:2] < 4'hA)
                        lut_mask[a_addr[5:2]] <= hwdata[15:0];
            endcase
        end
    end

    // chain ends: element 0 fed from the neighbouring block
    assign cz[0]   = 1'b0;
    assign co[0]   = 1'b1;
    assign lutc[0] = lut_chain_in;
    assign rch[0]  = reg_chain_in;

    // block carry selection at the fifth and tenth elements
    assign gsel0     = block_carry_in;
    assign gsel1     = gsel0 ? co[`LEM_GROUP] : cz[`LEM_GROUP];
    assign fin_carry = gsel1 ? co[`LEM_N] : cz[`LEM_N];

    genvar i;
    generate
        for (i = 0; i < `LEM_N; i++)
        begin : g_le
            lem_mode_type emode;
            logic         sub;
            logic         opa;
            logic         opb;
            logic         zin;
            logic         oin;
            logic         car;
            logic         lut_a;
            logic         d3s;
            logic         lut_v;
            logic         sum;
            logic         hold;

            assign emode = mode[i] ? LEM_ARITH : LEM_NORMAL;
            // subtract only in arithmetic; counters take up/down locally
            assign sub = (emode == LEM_ARITH) &&
                         (cnt[i] ? !fourth_data_input[i] : add_sub);
            assign opa = cnt[i] ? reg_q[i] : din_a[i];
            assign opb = din_b[i] ^ sub;
            // chain start takes the subtract select as its carry
            assign zin = start[i] ? sub : ((i == `LEM_GROUP) ? 1'b0 : cz[i]);
            assign oin = start[i] ? sub : ((i == `LEM_GROUP) ? 1'b1 : co[i]);
            // each chain carry picks that chain's carry-out
            assign cz[i+1] = zin ? (opa | opb) : (opa & opb);
            assign co[i+1] = oin ? (opa | opb) : (opa & opb);
            assign car = ((i < `LEM_GROUP) ? gsel0 : gsel1) ? oin : zin;
            assign sum = opa ^ opb ^ car;
            // normal table with carry or fourth input and table chain
            assign lut_a   = lchain[i] ? lutc[i] : din_a[i];
            assign d3s     = csel[i] ? car : fourth_data_input[i];
            assign lut_v   = lut_mask[i][{d3s, din_c[i], din_b[i], lut_a}];
            assign lutc[i+1] = lut_v;
            assign rch[i+1]  = reg_q[i];
            assign tout[i] = (emode == LEM_ARITH) ? sum : lut_v;
            // block-wide enable and clear picked per element
            assign ce_v[i]   = lab_clk_ena[ce_sel[i]];
            assign aclr_v[i] = async_clr[clr_sel[i]];
            assign hold      = cnt[i] && (emode == LEM_ARITH) && !din_c[i];

            // element register; asynchronous controls take effect at the clock edge
            always_ff @(posedge hclk or negedge hresetn)
            begin
                if (!hresetn)
                    reg_q[i] <= 1'b0;
                else if (clk_en)
                begin
                    if (rst_en && !chip_ok)
                        reg_q[i] <= 1'b0;
                    else if (aclr_v[i])
                        reg_q[i] <= 1'b0;
                    else if (async_load)
                        reg_q[i] <= preset[i] | fourth_data_input[i] & !preset[i];
                    else if (ce_v[i])
                    begin
                        if (sync_clr)
                            reg_q[i] <= 1'b0;
                        else if (sync_load)
                            reg_q[i] <= fourth_data_input[i];
                        else if (!hold)
                            reg_q[i] <= rsrc[i] ? rch[i] : tout[i];
                    end
                end
            end
        end
    endgenerate

    // outputs: table and register copies drive separate ports
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            comb_out        <= 10'h000;
            lut_chain_out   <= 1'b0;
            block_carry_out <= 1'b0;
        end
        else if (clk_en)
        begin
            comb_out        <= tout;
            lut_chain_out   <= lutc[`LEM_N];
            block_carry_out <= fin_carry;
        end
    end

    assign reg_out       = reg_q;
    assign reg_chain_out = reg_q[9];

    // reference adder for the checks below
    assign exp_sum = {1'b0, din_a} + {1'b0, din_b ^ {10{add_sub}}} + {10'h000, add_sub};

    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    property p_clr_wins;
        clk_en && !(rst_en && !chip_ok) && aclr_v[0] && async_load |=> reg_q[0] == 1'b0;
    endproperty
    a_clr_wins: assert property (p_clr_wins) else $error("clear lost to preset");

    property p_preset_high;
        clk_en && chip_ok && !aclr_v[0] && async_load && preset[0] |=> reg_q[0];
    endproperty
    a_preset_high: assert property (p_preset_high) else $error("preset not high");

    property p_load_data;
        clk_en && chip_ok && !aclr_v[0] && async_load && !preset[0]
            |=> reg_q[0] == $past(fourth_data_input[0]);
    endproperty
    a_load_data: assert property (p_load_data) else $error("load data wrong");

    property p_chip_reset;
        clk_en && rst_en && !chip_ok |=> reg_q == 10'h000;
    endproperty
    a_chip_reset: assert property (p_chip_reset) else $error("chip reset ignored");

    property p_sync_clr;
        clk_en && chip_ok && aclr_v == 10'h000 && !async_load && sync_clr && (&ce_v)
            |=> reg_q == 10'h000;
    endproperty
    a_sync_clr: assert property (p_sync_clr) else $error("sync clear missed");

    property p_ce_hold;
        clk_en && chip_ok && !aclr_v[0] && !async_load && !ce_v[0] |=> $stable(reg_q[0]);
    endproperty
    a_ce_hold: assert property (p_ce_hold) else $error("disabled clock moved reg");

    property p_freeze;
        !clk_en ##1 !clk_en |-> $stable(reg_q) && $stable(comb_out) && $stable(hrdata);
    endproperty
    a_freeze: assert property (p_freeze) else $error("state moved while frozen");

    property p_adder;
        clk_en && mode == 10'h3FF && start == 10'h001 && cnt == 10'h000
            |=> comb_out == $past(exp_sum[9:0]) && block_carry_out == $past(exp_sum[10]);
    endproperty
    a_adder: assert property (p_adder) else $error("adder result wrong");

    property p_normal_lut;
        clk_en && !mode[0] && !lchain[0] && !csel[0]
            |=> comb_out[0] ==
                $past(lut_mask[0][{fourth_data_input[0], din_c[0], din_b[0], din_a[0]}]);
    endproperty
    a_normal_lut: assert property (p_normal_lut) else $error("table output wrong");

endmodule

`default_nettype wire

// ### tb/lem_nbr_model.sv
`timescale 1ns/100ps
`default_nettype none

// lower-order neighbour block; its chain outputs leave flops, so ours sees them one edge late
module lem_nbr_model
(
    input  wire logic       hclk,      // system clock
    input  wire logic       hresetn,   // async reset, active low
    input  wire logic [9:0] lo_a,      // neighbour operand, added to itself
    input  wire logic       lo_chain,  // value in the neighbour's last register
    output logic            carry_out, // final carry of the neighbour sum
    output logic            lut_chain, // neighbour table chain, and of its operand
    output logic            reg_chain  // neighbour register chain
);
    logic [10:0] next_sum;

    // the neighbour adds its operand to itself, so a top bit of one gives a carry
    assign next_sum = {1'b0, lo_a} + {1'b0, lo_a};

    // registered like a real block; nothing held over reset
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            carry_out <= 1'b0;
            lut_chain <= 1'b0;
            reg_chain <= 1'b0;
        end
        else
        begin
            carry_out <= next_sum[10];
            lut_chain <= &lo_a;
            reg_chain <= lo_chain;
        end
    end
endmodule
`default_nettype wire

// ### tb/test_fpga_logic_element_modes.sv
`timescale 1ns/100ps
`default_nettype none
`include "lem_defines.svh"

module test_fpga_logic_element_modes;
    logic        hclk, hresetn, clk_en, hsel, hwrite, hreadyout, hresp;
    logic [31:0] haddr, hwdata, hrdata, rd;
    logic [1:0]  htrans, lab_clk_ena, async_clr;
    logic [9:0]  din_a, din_b, din_c, din_d, lo_a, comb_out, reg_out;
    logic        async_load, sync_clr, sync_load, add_sub, chip_n, lo_chain;
    logic        bcin, lcin, rcin, lut_co, reg_co, bco;
    logic [10:0] exp;
    int          err_total, check_count;
    logic [9:0]  va [6] = '{10'h3FF, 10'h01F, 10'h155, 10'h000, 10'h200, 10'h3FF};
    logic [9:0]  vb [6] = '{10'h001, 10'h001, 10'h2AA, 10'h001, 10'h0FF, 10'h3FF};
    logic        vs [6] = '{1'b0, 1'b0, 1'b0, 1'b1, 1'b1, 1'b1};

    lem_lab uut (
        .hclk(hclk), .hresetn(hresetn), .clk_en(clk_en), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .din_a(din_a), .din_b(din_b),
        .din_c(din_c), .fourth_data_input(din_d), .block_carry_in(bcin), .lut_chain_in(lcin),
        .reg_chain_in(rcin), .lab_clk_ena(lab_clk_ena), .async_clr(async_clr),
        .async_load(async_load), .sync_clr(sync_clr), .sync_load(sync_load), .add_sub(add_sub),
        .chip_wide_reset_n(chip_n), .comb_out(comb_out), .reg_out(reg_out),
        .lut_chain_out(lut_co), .reg_chain_out(reg_co), .block_carry_out(bco));

    lem_nbr_model nbr (
        .hclk(hclk), .hresetn(hresetn), .lo_a(lo_a), .lo_chain(lo_chain),
        .carry_out(bcin), .lut_chain(lcin), .reg_chain(rcin));

    // free-running bus clock
    initial
    begin
        hclk = 1'b0;
        forever #12.5 hclk = ~hclk;
    end

    task automatic cmp(input logic [31:0] got, input logic [31:0] want, input string what);
    begin
        check_count++;
        if (got !== want)
        begin
            err_total++;
            $display("ERROR %0t %s got %h want %h", $time, what, got, want);
        end
    end
    endtask

    // one single transfer; waits on hready in both phases, read data taken at the last edge
    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    begin
        haddr <= {24'h0, a};
        hwrite <= wr;
        htrans <= 2'b10;
        hsel <= 1'b1;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        htrans <= 2'b00;
        hwdata <= wd;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        rd = hrdata;
    end
    endtask

    // outputs are read at the edge after the one that took the inputs
    task automatic step(input int n);
        repeat (n) @(posedge hclk);
    endtask

    task automatic end_of_test;
    begin
        $display("checks %0d mismatches %0d", check_count, err_total);
        if (err_total == 0 && check_count > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    end
    endtask

    // cuts a hang short; the tests need well under a thousand cycles
    initial
    begin
        #(25 * 5000);
        err_total++;
        $display("ERROR %0t watchdog expired", $time);
        end_of_test();
    end

    initial
    begin
        {hresetn, clk_en, hsel, hwrite, htrans, haddr, hwdata} = '0;
        {din_a, din_b, din_c, din_d, lo_a, async_clr} = '0;
        {async_load, sync_clr, sync_load, add_sub, lo_chain} = '0;
        lab_clk_ena = 2'b11;
        chip_n = 1'b1;
        err_total = 0;
        check_count = 0;
        repeat (2) @(posedge hclk);
        hresetn <= 1'b1;
        clk_en <= 1'b1;
        step(2);
        // reset values, unmapped place, okay response
        bus(0, `LEM_OFF_MODE, 0);
        cmp(rd, 32'h0, "mode after reset");
        bus(0, `LEM_OFF_STATUS, 0);
        cmp(rd, 32'h0000_0800, "status after reset");
        bus(1, 8'hFC, 32'hFFFF_FFFF);
        bus(0, 8'hFC, 0);
        cmp(rd, 32'h0, "unmapped read");
        cmp(32'(hresp), 32'h0, "response");
        $display("test registers done");
        // normal mode: four-input and gate in every element
        for (int i = 0; i < 10; i++)
            bus(1, `LEM_OFF_LUT0 + 8'(4 * i), 32'h8000);
        {din_a, din_b, din_c, din_d} <= {4{10'h3FF}};
        add_sub <= 1'b1;
        step(2);
        cmp(32'(comb_out), 32'h3FF, "table all ones");
        cmp(32'(reg_out), 32'h3FF, "register all ones");
        din_c <= 10'h155;
        lab_clk_ena <= 2'b10;
        step(2);
        cmp(32'(comb_out), 32'h155, "table follows input");
        cmp(32'(reg_out), 32'h3FF, "register held");
        lab_clk_ena <= 2'b11;
        $display("test normal done");
        // arithmetic with a chain started at element zero
        bus(1, `LEM_OFF_MODE, 32'h3FF);
        bus(1, `LEM_OFF_START, 32'h001);
        for (int k = 0; k < 6; k++)
        begin
            din_a <= va[k];
            din_b <= vb[k];
            add_sub <= vs[k];
            exp = {1'b0, va[k]} + {1'b0, vb[k] ^ {10{vs[k]}}} + 11'(vs[k]);
            step(2);
            cmp(32'(comb_out), 32'(exp[9:0]), "sum");
            cmp(32'(reg_out), 32'(exp[9:0]), "registered sum");
            cmp(32'(bco), 32'(exp[10]), "final carry");
        end
        // no chain start: block carry from the neighbour picks the chain
        bus(1, `LEM_OFF_START, 32'h000);
        {din_a, din_b, add_sub, lo_a} <= {10'h001, 10'h002, 1'b0, 10'h3FF};
        step(3);
        cmp(32'(comb_out), 32'h004, "carry one selected");
        lo_a <= 10'h000;
        step(3);
        cmp(32'(comb_out), 32'h003, "carry zero selected");
        $display("test arithmetic done");
        // register controls in normal mode, table passes the fourth input
        bus(1, `LEM_OFF_MODE, 32'h0);
        {din_a, din_b, din_c, din_d, sync_load} <= {10'h3FF, 10'h3FF, 10'h3FF, 10'h155, 1'b1};
        step(2);
        cmp(32'(reg_out), 32'h155, "synchronous load");
        sync_clr <= 1'b1;
        step(2);
        cmp(32'(reg_out), 32'h000, "clear beats load");
        {sync_clr, sync_load, din_d} <= {1'b0, 1'b0, 10'h3FF};
        step(2);
        cmp(32'(reg_out), 32'h3FF, "table data");
        {async_clr, async_load} <= {2'b01, 1'b1};
        step(2);
        cmp(32'(reg_out), 32'h000, "clear beats load");
        {async_clr, din_d} <= {2'b00, 10'h0AA};
        step(2);
        cmp(32'(reg_out), 32'h0AA, "load from fourth input");
        bus(1, `LEM_OFF_PACK, 32'h3FF << `LEM_FLD_HI);
        step(2);
        cmp(32'(reg_out), 32'h3FF, "preset");
        bus(1, `LEM_OFF_CLKSEL, 32'h3FF << `LEM_FLD_MID);
        async_clr <= 2'b10;
        step(2);
        cmp(32'(reg_out), 32'h000, "second clear");
        bus(1, `LEM_OFF_CTRL, 32'h1);
        {async_clr, async_load, sync_load, din_d, chip_n} <= {3'b000, 1'b1, 10'h3FF, 1'b0};
        step(5);
        cmp(32'(reg_out), 32'h000, "chip reset overrides");
        bus(0, `LEM_OFF_STATUS, 0);
        // all-ones operands still ripple a carry out of the chain
        cmp(rd, 32'h0000_0400, "status under chip reset");
        {chip_n, sync_load, async_load} <= 3'b100;
        $display("test register controls done");
        // counter: operand is the own register, din_c enables, fourth input low counts down
        bus(1, `LEM_OFF_MODE, 32'h3FF);
        bus(1, `LEM_OFF_START, 32'h001);
        bus(1, `LEM_OFF_PACK, 32'h3FF << `LEM_FLD_MID);
        {sync_clr, din_b, din_c, din_d, add_sub} <= {1'b1, 10'h001, 10'h3FF, 10'h3FF, 1'b0};
        step(2);
        sync_clr <= 1'b0;
        step(4);
        cmp(32'(reg_out), 32'h003, "count up");
        din_d <= 10'h000;
        step(3);
        cmp(32'(reg_out), 32'h002, "count down");
        din_c <= 10'h000;
        step(3);
        cmp(32'(reg_out), 32'h001, "count hold");
        // register chain shift fed by the neighbour
        bus(1, `LEM_OFF_MODE, 32'h0);
        sync_clr <= 1'b1;
        bus(1, `LEM_OFF_PACK, 32'h3FF);
        lo_chain <= 1'b1;
        step(2);
        sync_clr <= 1'b0;
        step(4);
        cmp(32'(reg_out), 32'h007, "register chain shift");
        // global enable low must freeze the shifting chain
        clk_en <= 1'b0;
        step(3);
        cmp(32'(reg_out), 32'h00F, "frozen by clock enable");
        $display("test counter and chain done");
        end_of_test();
    end
endmodule
`default_nettype wire
